// ==== design/sas_pkg.sv ====
package sas_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_CONV_CTRL = 3'h0;
  localparam logic [2:0] OFF_PIN_REF = 3'h1;
  localparam logic [2:0] OFF_TIMING = 3'h2;
  localparam logic [2:0] OFF_RESULT_HIGH = 3'h3;
  localparam logic [2:0] OFF_RESULT_LOW = 3'h4;
  localparam logic [2:0] OFF_STATUS = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CC_ENABLE_BIT = 0;
  localparam int CC_GO_BIT = 1;
  localparam int CC_CHAN_LSB = 2;
  localparam int PR_PCFG_LSB = 0;
  localparam int PR_POS_REF_BIT = 4;
  localparam int PR_NEG_REF_BIT = 5;
  localparam int TF_CLK_LSB = 0;
  localparam int TF_ACQ_LSB = 3;
  localparam int TF_JUSTIFY_BIT = 7;
  localparam int ST_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------
  localparam logic [3:0] PCFG_FUSE_ONE = 4'h0;
  localparam logic [3:0] PCFG_FUSE_ZERO = 4'h7;
  localparam logic [3:0] PCFG_ALL_ANALOG = 4'h2;
  localparam int NUM_CHANNELS = 13;
  localparam int RESULT_BITS = 10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  // One instruction cycle is four oscillator periods
  localparam int INSTR_CYCLE_PS = 4 * CLK_PERIOD_PS;
  localparam int INSTR_CYCLE_CLKS = INSTR_CYCLE_PS / CLK_PERIOD_PS;
  localparam int CONV_TADS = 11;

  // Conversion clock select codes
  localparam logic [2:0] CS_DIV2 = 3'h0;
  localparam logic [2:0] CS_DIV8 = 3'h1;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_RC_A = 3'h3;
  localparam logic [2:0] CS_DIV4 = 3'h4;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  localparam logic [2:0] CS_RC_B = 3'h7;

  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_RC_WAIT = 2'b01,
    SAS_ACQUIRE = 2'b10,
    SAS_CONVERT = 2'b11
  } sas_state_t;

endpackage

// ==== design/sas_tad_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

module sas_tad_gen (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [2:0] i_sel,
  input wire logic i_rc_tick,
  output logic o_tad_tick
);

  // ----------------------------------------------------------------
  // Oscillator divide ratio minus one
  // ----------------------------------------------------------------
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    case (sel)
      sas_pkg::CS_DIV2: div_last = 6'h01;
      sas_pkg::CS_DIV4: div_last = 6'h03;
      sas_pkg::CS_DIV8: div_last = 6'h07;
      sas_pkg::CS_DIV16: div_last = 6'h0f;
      sas_pkg::CS_DIV32: div_last = 6'h1f;
      sas_pkg::CS_DIV64: div_last = 6'h3f;
      default: div_last = 6'h00;
    endcase
  endfunction

  logic [5:0] cnt_q;
  logic rc_sel;
  logic div_tick;

  assign rc_sel = (i_sel == sas_pkg::CS_RC_A) || (i_sel == sas_pkg::CS_RC_B);
  assign div_tick = (cnt_q == div_last(i_sel));

  // Restarted while idle so the first period is always a full one
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_run || div_tick) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // The RC source runs on its own, so its tick is passed straight through
  assign o_tad_tick = i_run && (rc_sel ? i_rc_tick : div_tick); // R10

endmodule

`default_nettype wire

// ==== design/sas_adc_ctrl.sv ====
// Notes on behaviour
// (R1) Thirteen inputs, ten-bit result
// (R2) Channel field picks input 0 to 12
// (R3) Go bit reads 1 while converting
// (R4) Enable bit switches converter on
// (R5) Reference select bits pick pin or supply
// (R6) Pin config turns pins digital from top
// (R7) Pin config reset value follows fuse
// (R8) Justify bit picks right or left layout
// (R9) Acquisition code sets delay in periods
// (R10) Clock select picks divider or RC
// (R11) RC source adds one instruction cycle
// (R12) Software picks RC for sleep conversions
// (R13) Result by successive approximation
// (R14) Reset clears registers, aborts conversion
// (R15) Completion stores result, clears go, flags
// (R16) Result pair untouched by reset
// (R17) Software waits acquisition when code zero
// (R18) Nonzero delay inserted before conversion
// (R19) Software configures, enables, starts, polls
// (R20) Software waits two periods between conversions
// (R21) Unused register bits read zero
// (R22) Conversion takes eleven clock periods
// (R23) Start samples for delay, then converts
// (R24) Sampling resumes after each conversion
// (R25) Start ignored when disabled; flag sticky
// (R26) Unused channel codes convert normally
`timescale 1ns/1ps
`default_nettype none

module sas_adc_ctrl #(
  parameter int NUM_CH = sas_pkg::NUM_CHANNELS,
  parameter int RES_W = sas_pkg::RESULT_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_portb_analog_fuse,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rc_tick,
  input wire logic i_comp_high,
  output logic [3:0] o_channel,
  output logic [NUM_CH-1:0] o_pin_analog,
  output logic o_vref_neg_ext,
  output logic o_vref_pos_ext,
  output logic o_sample,
  output logic [RES_W-1:0] o_dac_code,
  output logic o_done_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Acquisition code to number of conversion-clock periods
  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    case (code)
      3'h1: acq_periods = 5'h02;
      3'h2: acq_periods = 5'h04;
      3'h3: acq_periods = 5'h06;
      3'h4: acq_periods = 5'h08;
      3'h5: acq_periods = 5'h0c;
      3'h6: acq_periods = 5'h10;
      3'h7: acq_periods = 5'h14;
      default: acq_periods = 5'h00;
    endcase
  endfunction

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel == sas_pkg::CS_RC_A) || (sel == sas_pkg::CS_RC_B);
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic enable_q;
  logic [3:0] channel_q;
  logic neg_ref_q;
  logic pos_ref_q;
  logic [3:0] pcfg_q;
  logic justify_q;
  logic [2:0] acq_sel_q;
  logic [2:0] clk_sel_q;
  logic done_flag_q;
  logic [7:0] result_high_q;
  logic [7:0] result_low_q;
  logic [7:0] rdata_q;

  logic wr_cc;
  logic wr_pr;
  logic wr_tf;
  logic wr_st;
  logic start_req;
  logic finish;

  sas_pkg::sas_state_t state_q;
  sas_pkg::sas_state_t state_d;

  assign wr_cc = i_wr && (i_addr == sas_pkg::OFF_CONV_CTRL);
  assign wr_pr = i_wr && (i_addr == sas_pkg::OFF_PIN_REF);
  assign wr_tf = i_wr && (i_addr == sas_pkg::OFF_TIMING);
  assign wr_st = i_wr && (i_addr == sas_pkg::OFF_STATUS);

  // A start needs the enable bit set in the same write, even when the module is already on
  assign start_req = wr_cc && i_wdata[sas_pkg::CC_GO_BIT] &&
                     i_wdata[sas_pkg::CC_ENABLE_BIT] &&
                     (state_q == sas_pkg::SAS_IDLE); // R25

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      enable_q <= 1'b0; // R14
      channel_q <= 4'h0;
    end else if (wr_cc) begin
      enable_q <= i_wdata[sas_pkg::CC_ENABLE_BIT]; // R4
      channel_q <= i_wdata[sas_pkg::CC_CHAN_LSB +: 4]; // R2
    end
  end

  // Fuse is a static strap, sampled while reset is held
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      neg_ref_q <= 1'b0;
      pos_ref_q <= 1'b0;
      pcfg_q <= i_portb_analog_fuse ? sas_pkg::PCFG_FUSE_ONE
                                    : sas_pkg::PCFG_FUSE_ZERO; // R7
    end else if (wr_pr) begin
      neg_ref_q <= i_wdata[sas_pkg::PR_NEG_REF_BIT];
      pos_ref_q <= i_wdata[sas_pkg::PR_POS_REF_BIT];
      pcfg_q <= i_wdata[sas_pkg::PR_PCFG_LSB +: 4];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      justify_q <= 1'b0;
      acq_sel_q <= 3'h0;
      clk_sel_q <= 3'h0;
    end else if (wr_tf) begin
      justify_q <= i_wdata[sas_pkg::TF_JUSTIFY_BIT];
      acq_sel_q <= i_wdata[sas_pkg::TF_ACQ_LSB +: 3];
      clk_sel_q <= i_wdata[sas_pkg::TF_CLK_LSB +: 3];
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      done_flag_q <= 1'b0;
    end else if (finish) begin
      done_flag_q <= 1'b1; // R15
    end else if (wr_st && !i_wdata[sas_pkg::ST_DONE_BIT]) begin
      done_flag_q <= 1'b0; // R25
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic tad_tick;
  logic [1:0] rc_wait_q;
  logic [4:0] acq_cnt_q;
  logic [3:0] conv_cnt_q;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] trial_q;
  logic run_tad;

  assign run_tad = (state_q == sas_pkg::SAS_ACQUIRE) ||
                   (state_q == sas_pkg::SAS_CONVERT);

  sas_tad_gen u_tad_gen (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_run(run_tad),
    .i_sel(clk_sel_q),
    .i_rc_tick(i_rc_tick),
    .o_tad_tick(tad_tick)
  );

  assign finish = (state_q == sas_pkg::SAS_CONVERT) && tad_tick &&
                  (conv_cnt_q == 4'(sas_pkg::CONV_TADS - 1)); // R22

  always_comb begin
    state_d = state_q;
    case (state_q)
      sas_pkg::SAS_IDLE: begin
        if (start_req) begin
          if (is_rc(clk_sel_q)) begin
            state_d = sas_pkg::SAS_RC_WAIT; // R11
          end else if (acq_sel_q != 3'h0) begin
            state_d = sas_pkg::SAS_ACQUIRE; // R18
          end else begin
            state_d = sas_pkg::SAS_CONVERT; // R23
          end
        end
      end
      sas_pkg::SAS_RC_WAIT: begin
        if (rc_wait_q == 2'(sas_pkg::INSTR_CYCLE_CLKS - 1)) begin
          state_d = (acq_sel_q != 3'h0) ? sas_pkg::SAS_ACQUIRE
                                        : sas_pkg::SAS_CONVERT;
        end
      end
      sas_pkg::SAS_ACQUIRE: begin
        if (tad_tick && (acq_cnt_q == acq_periods(acq_sel_q) - 5'h01)) begin
          state_d = sas_pkg::SAS_CONVERT; // R9
        end
      end
      sas_pkg::SAS_CONVERT: begin
        if (finish) begin
          state_d = sas_pkg::SAS_IDLE; // R24
        end
      end
      default: state_d = sas_pkg::SAS_IDLE;
    endcase
    // Switching the module off abandons any conversion; a start that
    // switches the module on in the same write must still get through
    if (!enable_q && !start_req) begin
      state_d = sas_pkg::SAS_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= sas_pkg::SAS_IDLE; // R14
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || state_q != sas_pkg::SAS_RC_WAIT) begin
      rc_wait_q <= 2'h0;
    end else begin
      rc_wait_q <= rc_wait_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || state_q != sas_pkg::SAS_ACQUIRE) begin
      acq_cnt_q <= 5'h00;
    end else if (tad_tick) begin
      acq_cnt_q <= acq_cnt_q + 5'h01;
    end
  end

  // First period disconnects the hold cap, then one bit per period
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || state_q != sas_pkg::SAS_CONVERT) begin
      conv_cnt_q <= 4'h0;
      sar_q <= '0;
      trial_q <= {1'b1, {(RES_W-1){1'b0}}};
    end else if (tad_tick && conv_cnt_q != 4'h0) begin
      conv_cnt_q <= conv_cnt_q + 4'h1;
      // Keep the trial bit when the input sits above the trial level
      if (i_comp_high) begin
        sar_q <= sar_q | trial_q; // R13
      end
      trial_q <= trial_q >> 1;
    end else if (tad_tick) begin
      conv_cnt_q <= 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Result pair
  // ----------------------------------------------------------------
  logic [RES_W-1:0] final_res;

  assign final_res = i_comp_high ? (sar_q | trial_q) : sar_q;

  // No reset: contents stay as they were across a reset
  always_ff @(posedge i_clk) begin
    if (finish) begin // R16
      if (justify_q) begin
        result_high_q <= {6'h00, final_res[9:8]}; // R8
        result_low_q <= final_res[7:0];
      end else begin
        result_high_q <= final_res[9:2];
        result_low_q <= {final_res[1:0], 6'h00};
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic busy;

  assign busy = enable_q && (state_q != sas_pkg::SAS_IDLE); // R3

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_rd) begin
      rdata_q <= 8'h00;
    end else begin
      case (i_addr)
        sas_pkg::OFF_CONV_CTRL:
          rdata_q <= {2'b00, channel_q, busy, enable_q}; // R21
        sas_pkg::OFF_PIN_REF:
          rdata_q <= {2'b00, neg_ref_q, pos_ref_q, pcfg_q};
        sas_pkg::OFF_TIMING:
          rdata_q <= {justify_q, 1'b0, acq_sel_q, clk_sel_q};
        sas_pkg::OFF_RESULT_HIGH: rdata_q <= result_high_q;
        sas_pkg::OFF_RESULT_LOW: rdata_q <= result_low_q;
        sas_pkg::OFF_STATUS: rdata_q <= {7'h00, done_flag_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Analog-side controls
  // ----------------------------------------------------------------
  // Codes up to the all-analog limit keep every pin analog; each code
  // above it makes one more pin digital from the top down
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (pcfg_q <= sas_pkg::PCFG_ALL_ANALOG) begin
        o_pin_analog[i] = 1'b1; // R6
      end else begin
        o_pin_analog[i] =
          (i < NUM_CH - int'(pcfg_q) + int'(sas_pkg::PCFG_ALL_ANALOG));
      end
    end
  end

  // Unused codes go straight through to the mux and convert as usual
  assign o_channel = channel_q; // R26
  assign o_vref_neg_ext = neg_ref_q; // R5
  assign o_vref_pos_ext = pos_ref_q;
  // Sampling runs whenever the module is on and not converting
  assign o_sample = enable_q && (state_q != sas_pkg::SAS_CONVERT); // R24
  assign o_dac_code = sar_q | trial_q; // R1
  assign o_done_flag = done_flag_q;
  assign o_rdata = rdata_q;

endmodule

`default_nettype wire

// ==== verification/sas_adc_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module sas_adc_ctrl_chk #(
  parameter int NUM_CH = 13,
  parameter int RES_W = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_portb_analog_fuse,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_rc_tick,
  input wire logic i_comp_high,
  input wire logic [3:0] o_channel,
  input wire logic [NUM_CH-1:0] o_pin_analog,
  input wire logic o_vref_neg_ext,
  input wire logic o_vref_pos_ext,
  input wire logic o_sample,
  input wire logic [RES_W-1:0] o_dac_code,
  input wire logic o_done_flag
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [NUM_CH-1:0] pin_exp(input logic [3:0] c);
    return (c < 4'h3) ? 13'h1fff : 13'h1fff >> (c - 4'h2);
  endfunction
  // Bits that must read zero; unmapped offsets read zero whole
  function automatic logic [7:0] rsv(input logic [2:0] a);
    case (a)
      3'h0, 3'h1: return 8'hc0;
      3'h2: return 8'h40;
      3'h3, 3'h4: return 8'h00;
      3'h5: return 8'hfe;
      default: return 8'hff;
    endcase
  endfunction
  logic wr_cc, wr_pr, clr;
  assign wr_cc = i_wr && i_addr == sas_pkg::OFF_CONV_CTRL;
  assign wr_pr = i_wr && i_addr == sas_pkg::OFF_PIN_REF;
  assign clr = i_wr && i_addr == sas_pkg::OFF_STATUS && !i_wdata[0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_rsv_zero;
    $past(i_rd) |-> (o_rdata & rsv($past(i_addr))) == 8'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved read bits not zero");
  property p_pin_map;
    wr_pr |=> o_pin_analog == pin_exp($past(i_wdata[3:0]));
  endproperty
  a_pin_map: assert property (p_pin_map)
    else $error("pin analog map wrong");
  property p_vref;
    wr_pr |=> {o_vref_neg_ext, o_vref_pos_ext} == $past(i_wdata[5:4]);
  endproperty
  a_vref: assert property (p_vref)
    else $error("reference select wrong");
  property p_chan;
    wr_cc |=> o_channel == $past(i_wdata[5:2]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel select wrong");
  property p_rst_pins;
    $rose(i_rst_n) |-> o_pin_analog ==
      ($past(i_portb_analog_fuse) ? pin_exp(4'h0) : pin_exp(4'h7));
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("pin config reset value wrong");
  property p_rst_state;
    $rose(i_rst_n) |-> !o_done_flag && !o_sample && o_dac_code == 10'h200;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("converter not idle after reset");
  property p_flag_sticky;
    o_done_flag && !clr |=> o_done_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("done flag dropped without clear");
  property p_off_no_sample;
    wr_cc && !i_wdata[0] |=> !o_sample [*2];
  endproperty
  a_off_no_sample: assert property (p_off_no_sample)
    else $error("sampling while disabled");
  property p_done_samples;
    $rose(o_done_flag) |-> o_sample;
  endproperty
  a_done_samples: assert property (p_done_samples)
    else $error("sampling not resumed after conversion");
  c_done: cover property ($rose(o_done_flag));
  c_clear: cover property (o_done_flag && clr);
  c_pin_all_dig: cover property (wr_pr && i_wdata[3:0] == 4'hf);
endmodule
bind sas_adc_ctrl sas_adc_ctrl_chk #(.NUM_CH(NUM_CH), .RES_W(RES_W))
  sas_adc_ctrl_chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_portb_analog_fuse(i_portb_analog_fuse), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_rc_tick(i_rc_tick), .i_comp_high(i_comp_high),
  .o_channel(o_channel), .o_pin_analog(o_pin_analog),
  .o_vref_neg_ext(o_vref_neg_ext), .o_vref_pos_ext(o_vref_pos_ext),
  .o_sample(o_sample), .o_dac_code(o_dac_code),
  .o_done_flag(o_done_flag));
`default_nettype wire

// ==== verification/sas_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model #(
  parameter int RC_DIV = 5
) (
  input wire logic i_clk,
  input wire logic [3:0] i_channel,
  input wire logic i_sample,
  input wire logic [9:0] i_dac_code,
  output logic o_comp_high,
  output logic o_rc_tick
);
  // Pin levels per channel code; codes above 12 hold a settable level like any other
  logic [9:0] level [16];
  logic [9:0] held_q = 10'h000;
  int rc_q = 0;
  initial begin
    for (int k = 0; k < 16; k++) begin
      level[k] = 10'h2aa;
    end
  end
  // Hold capacitor tracks the pin only while the switch is closed
  always @(posedge i_clk) begin
    if (i_sample) begin
      held_q <= level[i_channel];
    end
  end
  assign o_comp_high = held_q >= i_dac_code;
  // RC source runs free, so its phase against a start is unknown
  always @(posedge i_clk) begin
    rc_q <= (rc_q == RC_DIV - 1) ? 0 : rc_q + 1;
  end
  assign o_rc_tick = rc_q == 0;
endmodule
`default_nettype wire

// ==== verification/tb_sas_adc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb_sas_adc_ctrl;
  localparam int RC = 5;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_fuse = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata, d;
  logic comp, rc, o_vn, o_vp, o_sample, o_flag;
  logic [3:0] o_channel;
  logic [12:0] o_pins;
  logic [9:0] o_dac;
  logic [31:0] seed = 32'h00000053;
  logic [31:0] r;
  int errors = 0;
  int checks = 0;
  sas_adc_ctrl sas_adc_ctrl_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_portb_analog_fuse(i_fuse),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_rc_tick(rc), .i_comp_high(comp),
    .o_channel(o_channel), .o_pin_analog(o_pins), .o_vref_neg_ext(o_vn),
    .o_vref_pos_ext(o_vp), .o_sample(o_sample), .o_dac_code(o_dac),
    .o_done_flag(o_flag));
  sas_analog_model #(.RC_DIV(RC)) sas_analog_model_inst (
    .i_clk(i_clk), .i_channel(o_channel), .i_sample(o_sample),
    .i_dac_code(o_dac), .o_comp_high(comp), .o_rc_tick(rc));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [12:0] pin_exp(input logic [3:0] c);
    return (c < 4'h3) ? 13'h1fff : 13'h1fff >> (c - 4'h2);
  endfunction
  function automatic int acqp(input logic [2:0] a);
    return (a < 3'h5) ? 2 * a : 4 * a - 8;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic rst(input logic f);
    i_fuse <= f;
    i_rst_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One conversion; RC start phase is free, so its window is one period
  task automatic conv(input logic [3:0] ch, input logic [2:0] cs,
                      input logic [2:0] acq, input logic j);
    int n, lo, tad;
    logic [9:0] v;
    v = 10'(xs());
    sas_analog_model_inst.level[ch] = v;
    tad = (cs[1:0] == 2'b11) ? RC : 2 << (2 * cs[1:0] + cs[2]);
    lo = (acqp(acq) + 11) * tad + ((cs[1:0] == 2'b11) ? 4 - tad : 0);
    wr(sas_pkg::OFF_TIMING, {j, 1'b1, acq, cs});
    wr(sas_pkg::OFF_CONV_CTRL, {2'b11, ch, 2'b01});
    wr(sas_pkg::OFF_STATUS, 8'h00);
    #1;
    `CHK(o_flag, 1'b0)
    // Manual settling time on the freshly selected channel
    repeat (2 * tad) @(posedge i_clk);
    wr(sas_pkg::OFF_CONV_CTRL, {2'b00, ch, 2'b11});
    n = 0;
    while (o_flag !== 1'b1 && n < 4000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    `CHK(n >= lo && n <= lo + ((cs[1:0] == 2'b11) ? tad : 0) + 3, 1'b1)
    `CHK(o_sample, 1'b1)
    rd(sas_pkg::OFF_CONV_CTRL);
    `CHK(d, {2'b00, ch, 2'b01})
    rd(sas_pkg::OFF_TIMING);
    `CHK(d, {j, 1'b0, acq, cs})
    rd(sas_pkg::OFF_RESULT_HIGH);
    `CHK(d, j ? {6'h00, v[9:8]} : v[9:2])
    rd(sas_pkg::OFF_RESULT_LOW);
    `CHK(d, j ? v[7:0] : {v[1:0], 6'h00})
    // Gap before the next acquisition may start
    repeat (2 * tad) @(posedge i_clk);
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #200000;
    errors++;
    close_out();
  end
  initial begin
    rst(1'b0);
    @(posedge i_clk);
    #1;
    `CHK(o_pins, 13'h00ff)
    for (int a = 0; a < 8; a++) begin
      if (a != 3 && a != 4) begin
        rd(a[2:0]);
        `CHK(d, (a == 1) ? 8'h07 : 8'h00)
      end
    end
    for (int c = 0; c < 16; c++) begin
      r = xs();
      wr(sas_pkg::OFF_PIN_REF, {2'b11, r[1:0], c[3:0]});
      wr(sas_pkg::OFF_CONV_CTRL, {2'b11, c[3:0], 2'b00});
      #1;
      `CHK(o_pins, pin_exp(c[3:0]))
      `CHK({o_vn, o_vp}, r[1:0])
      `CHK(o_channel, c[3:0])
      rd(sas_pkg::OFF_PIN_REF);
      `CHK(d, {2'b00, r[1:0], c[3:0]})
    end
    wr(sas_pkg::OFF_PIN_REF, 8'h00);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      conv(r[3:0], i[2:0], 3'(i * 3), r[4]);
    end
    // Switching off mid-conversion must abort without a flag
    wr(sas_pkg::OFF_STATUS, 8'h00);
    wr(sas_pkg::OFF_TIMING, 8'h06);
    wr(sas_pkg::OFF_CONV_CTRL, 8'h03);
    rd(sas_pkg::OFF_CONV_CTRL);
    `CHK(d, 8'h03)
    wr(sas_pkg::OFF_CONV_CTRL, 8'h00);
    repeat (800) @(posedge i_clk);
    `CHK({o_flag, o_sample}, 2'b00)
    wr(sas_pkg::OFF_CONV_CTRL, 8'h02);
    repeat (800) @(posedge i_clk);
    rd(sas_pkg::OFF_CONV_CTRL);
    `CHK({d, o_flag}, 9'h000)
    // Reset in mid-conversion keeps the low result byte untouched
    rd(sas_pkg::OFF_RESULT_LOW);
    r[7:0] = d;
    wr(sas_pkg::OFF_RESULT_LOW, ~d);
    wr(sas_pkg::OFF_CONV_CTRL, 8'h03);
    repeat (50) @(posedge i_clk);
    rd(sas_pkg::OFF_CONV_CTRL);
    `CHK(d, 8'h03)
    rst(1'b1);
    @(posedge i_clk);
    #1;
    `CHK(o_pins, 13'h1fff)
    rd(sas_pkg::OFF_CONV_CTRL);
    `CHK(d, 8'h00)
    rd(sas_pkg::OFF_RESULT_LOW);
    `CHK(d, r[7:0])
    close_out();
  end
endmodule
`default_nettype wire
